/* rtl/stl_pkg.sv */
// Constants and types for the scan trigger layer controller.
// Assumes a 40 MHz clock and a classic Wishbone register bus.
package stl_pkg;
    localparam int unsigned CLK_NS = 25;
    localparam int unsigned TICK_NS = 1000000;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SRC = 8'h04;
    localparam logic [7:0] A_CCNT = 8'h08;
    localparam logic [7:0] A_ACNT = 8'h0C;
    localparam logic [7:0] A_DLY2 = 8'h10;
    localparam logic [7:0] A_DLYC = 8'h14;
    localparam logic [7:0] A_TMR = 8'h18;
    localparam logic [7:0] A_CMD = 8'h1C;
    localparam logic [7:0] A_STAT = 8'h20;
    localparam int CMD_START = 0;
    localparam int CMD_ABORT = 1;
    localparam int CMD_SIGNAL = 2;
    localparam int CMD_BUSTRG = 3;
    localparam int SRC_A1_LSB = 0;
    localparam int SRC_A2_LSB = 4;
    localparam int SRC_CH_LSB = 8;
    localparam int STAT_BUSY = 3;
    localparam logic [26:0] DLY_MAX_MS = 27'h5F5E0FF;
    localparam logic [26:0] DLY_RST = 27'h0;
    localparam logic [15:0] CNT_RST = 16'h1;
    localparam logic [26:0] TMR_RST = 27'h3E8;
    typedef enum logic [2:0] {
        SRC_HOLD, SRC_PASS, SRC_MANUAL, SRC_BUS, SRC_TLINE, SRC_EXT, SRC_TIMER
    } stl_src_t;
    localparam stl_src_t SRC_RST = SRC_PASS;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ARM1, ST_ARM2, ST_DLY2, ST_TRIG, ST_DLYC, ST_STEP
    } stl_state_t;
    typedef struct packed {
        logic manual;
        logic ext;
        logic tline;
    } stl_pins_t;
endpackage

/* rtl/stl_top.sv */
// Trigger model for two arm layers and a channel layer, with register port.
// Assumes pins asynchronous to clk_i and scan_len_i from logic on clk_i.
`timescale 1ns/10ps
module stl_top #(
    parameter int unsigned TICK_CYC = stl_pkg::TICK_NS / stl_pkg::CLK_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] scan_len_i,
    input wire stl_pkg::stl_pins_t pins_i,
    output logic chan_step_o,
    output logic busy_o
);
    typedef struct packed {
        stl_pkg::stl_state_t st;
        logic ack;
        logic [31:0] rdat;
        logic auto_on;
        stl_pkg::stl_src_t src1;
        stl_pkg::stl_src_t src2;
        stl_pkg::stl_src_t srcc;
        logic [15:0] cnt1;
        logic [15:0] cnt2;
        logic [15:0] cntc;
        logic [26:0] dly2;
        logic [26:0] dlyc;
        logic [26:0] tint;
        logic [15:0] n1;
        logic [15:0] n2;
        logic [15:0] nc;
        logic [26:0] dms;
        logic [15:0] pre;
        logic [26:0] tms;
        logic [15:0] tpre;
        logic tpend;
        logic first;
        logic step;
        logic busy;
        stl_pkg::stl_pins_t s1;
        stl_pkg::stl_pins_t s2;
        stl_pkg::stl_pins_t s3;
    } stl_regs_t;

    stl_regs_t s_r;
    stl_regs_t s_nxt;
    logic wr_acc;
    logic [31:0] cur;
    logic [31:0] wv;
    logic start_w;
    logic abort_w;
    logic sig_w;
    logic bus_w;
    stl_pkg::stl_pins_t evt;
    logic tick_dly;
    logic dly_done;
    logic tick_tmr;
    logic ok1;
    logic ok2;
    logic okc;

    function automatic logic src_ok(input stl_pkg::stl_src_t s, input stl_pkg::stl_pins_t e,
                                    input logic bus, input logic sig, input logic tmr);
        case (s)
            stl_pkg::SRC_HOLD: src_ok = sig;
            stl_pkg::SRC_PASS: src_ok = 1'b1;
            stl_pkg::SRC_MANUAL: src_ok = e.manual;
            stl_pkg::SRC_BUS: src_ok = bus;
            stl_pkg::SRC_TLINE: src_ok = e.tline;
            stl_pkg::SRC_EXT: src_ok = e.ext;
            default: src_ok = tmr;
        endcase
    endfunction

    function automatic logic [26:0] clamp_ms(input logic [31:0] v);
        clamp_ms = (v > {5'h0, stl_pkg::DLY_MAX_MS}) ? stl_pkg::DLY_MAX_MS : v[26:0];
    endfunction

    // Read view of the register file
    always_comb begin
        if (wb_adr_i == stl_pkg::A_CTRL) begin
            cur = {31'h0, s_r.auto_on};
        end else if (wb_adr_i == stl_pkg::A_SRC) begin
            cur = {21'h0, s_r.srcc, 1'b0, s_r.src2, 1'b0, s_r.src1};
        end else if (wb_adr_i == stl_pkg::A_CCNT) begin
            cur = {16'h0, s_r.cntc};
        end else if (wb_adr_i == stl_pkg::A_ACNT) begin
            cur = {s_r.cnt2, s_r.cnt1};
        end else if (wb_adr_i == stl_pkg::A_DLY2) begin
            cur = {5'h0, s_r.dly2};
        end else if (wb_adr_i == stl_pkg::A_DLYC) begin
            cur = {5'h0, s_r.dlyc};
        end else if (wb_adr_i == stl_pkg::A_TMR) begin
            cur = {5'h0, s_r.tint};
        end else if (wb_adr_i == stl_pkg::A_STAT) begin
            cur = {s_r.nc, 12'h0, s_r.busy, s_r.st};
        end else begin
            cur = 32'h0;
        end
    end

    // Byte lanes not selected keep their old contents
    assign wv = {wb_sel_i[3] ? wb_dat_i[31:24] : cur[31:24],
                 wb_sel_i[2] ? wb_dat_i[23:16] : cur[23:16],
                 wb_sel_i[1] ? wb_dat_i[15:8] : cur[15:8],
                 wb_sel_i[0] ? wb_dat_i[7:0] : cur[7:0]};
    assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack;
    assign start_w = wr_acc && wb_adr_i == stl_pkg::A_CMD && wb_dat_i[stl_pkg::CMD_START];
    assign abort_w = wr_acc && wb_adr_i == stl_pkg::A_CMD && wb_dat_i[stl_pkg::CMD_ABORT];
    assign sig_w = wr_acc && wb_adr_i == stl_pkg::A_CMD && wb_dat_i[stl_pkg::CMD_SIGNAL];
    assign bus_w = wr_acc && wb_adr_i == stl_pkg::A_CMD && wb_dat_i[stl_pkg::CMD_BUSTRG];
    // Edges from second and third stages only
    assign evt = s_r.s2 & ~s_r.s3;
    assign tick_dly = s_r.pre == 16'(TICK_CYC - 1);
    assign tick_tmr = s_r.tpre == 16'(TICK_CYC - 1);
    assign dly_done = (s_r.st == stl_pkg::ST_DLY2) ? s_r.dms == s_r.dly2 : s_r.dms == s_r.dlyc;
    assign ok1 = src_ok(s_r.src1, evt, bus_w, sig_w, s_r.first | s_r.tpend);
    assign ok2 = src_ok(s_r.src2, evt, bus_w, sig_w, s_r.first | s_r.tpend);
    assign okc = src_ok(s_r.srcc, evt, bus_w, sig_w, s_r.first | s_r.tpend);

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = pins_i;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        s_nxt.step = 1'b0;
        // One-cycle ack per request, dropped the cycle after
        s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
        if (wb_cyc_i & wb_stb_i & ~s_r.ack) begin
            s_nxt.rdat = cur;
        end
        if (wr_acc) begin
            if (wb_adr_i == stl_pkg::A_CTRL) begin
                s_nxt.auto_on = wv[0];
            end else if (wb_adr_i == stl_pkg::A_SRC) begin
                s_nxt.src1 = stl_pkg::stl_src_t'(wv[stl_pkg::SRC_A1_LSB +: 3]);
                s_nxt.src2 = stl_pkg::stl_src_t'(wv[stl_pkg::SRC_A2_LSB +: 3]);
                s_nxt.srcc = stl_pkg::stl_src_t'(wv[stl_pkg::SRC_CH_LSB +: 3]);
            end else if (wb_adr_i == stl_pkg::A_CCNT) begin
                s_nxt.cntc = wv[15:0];
                s_nxt.auto_on = 1'b0;
            end else if (wb_adr_i == stl_pkg::A_ACNT) begin
                s_nxt.cnt1 = wv[15:0];
                s_nxt.cnt2 = wv[31:16];
            end else if (wb_adr_i == stl_pkg::A_DLY2) begin
                s_nxt.dly2 = clamp_ms(wv);
            end else if (wb_adr_i == stl_pkg::A_DLYC) begin
                s_nxt.dlyc = clamp_ms(wv);
            end else if (wb_adr_i == stl_pkg::A_TMR) begin
                s_nxt.tint = (wv[26:0] == 27'h0) ? 27'h1 : wv[26:0];
            end
        end
        // Follows every cycle, so enable and later list edits both land
        if (s_nxt.auto_on) begin
            s_nxt.cntc = (scan_len_i == 16'h0) ? 16'h1 : scan_len_i;
        end
        // Free interval timer while a run is active
        if (s_r.busy) begin
            s_nxt.tpre = tick_tmr ? 16'h0 : s_r.tpre + 16'h1;
            if (tick_tmr) begin
                s_nxt.tms = s_r.tms + 27'h1;
            end
        end
        // Delay prescaler, one count per millisecond
        s_nxt.pre = tick_dly ? 16'h0 : s_r.pre + 16'h1;
        if (tick_dly && !dly_done) begin
            s_nxt.dms = s_r.dms + 27'h1;
        end
        case (s_r.st)
            stl_pkg::ST_IDLE: begin
                if (start_w) begin
                    s_nxt.st = stl_pkg::ST_ARM1;
                    s_nxt.busy = 1'b1;
                    s_nxt.first = 1'b1;
                    s_nxt.n1 = 16'h0;
                    s_nxt.tms = 27'h0;
                    s_nxt.tpre = 16'h0;
                    s_nxt.tpend = 1'b0;
                end
            end
            stl_pkg::ST_ARM1: begin
                if (ok1) begin
                    s_nxt.st = stl_pkg::ST_ARM2;
                    s_nxt.first = 1'b1;
                    s_nxt.n2 = 16'h0;
                    if (s_r.src1 == stl_pkg::SRC_TIMER && !s_r.first) begin
                        s_nxt.tpend = 1'b0;
                    end
                end
            end
            stl_pkg::ST_ARM2: begin
                if (ok2) begin
                    s_nxt.st = stl_pkg::ST_DLY2;
                    s_nxt.first = 1'b0;
                    s_nxt.dms = 27'h0;
                    s_nxt.pre = 16'h0;
                    if (s_r.src2 == stl_pkg::SRC_TIMER && !s_r.first) begin
                        s_nxt.tpend = 1'b0;
                    end
                end
            end
            stl_pkg::ST_DLY2: begin
                if (dly_done) begin
                    s_nxt.st = stl_pkg::ST_TRIG;
                    s_nxt.first = 1'b1;
                    s_nxt.nc = 16'h0;
                end
            end
            stl_pkg::ST_TRIG: begin
                if (okc) begin
                    s_nxt.st = stl_pkg::ST_DLYC;
                    s_nxt.first = 1'b0;
                    s_nxt.dms = 27'h0;
                    s_nxt.pre = 16'h0;
                    if (s_r.srcc == stl_pkg::SRC_TIMER && !s_r.first) begin
                        s_nxt.tpend = 1'b0;
                    end
                end
            end
            stl_pkg::ST_DLYC: begin
                if (dly_done) begin
                    s_nxt.st = stl_pkg::ST_STEP;
                end
            end
            default: begin
                // A count of zero loops forever
                s_nxt.step = 1'b1;
                s_nxt.nc = s_r.nc + 16'h1;
                s_nxt.first = 1'b0;
                s_nxt.st = stl_pkg::ST_TRIG;
                if (s_r.cntc != 16'h0 && s_r.nc + 16'h1 >= s_r.cntc) begin
                    s_nxt.n2 = s_r.n2 + 16'h1;
                    s_nxt.st = stl_pkg::ST_ARM2;
                    if (s_r.cnt2 != 16'h0 && s_r.n2 + 16'h1 >= s_r.cnt2) begin
                        s_nxt.n1 = s_r.n1 + 16'h1;
                        s_nxt.st = stl_pkg::ST_ARM1;
                        if (s_r.cnt1 != 16'h0 && s_r.n1 + 16'h1 >= s_r.cnt1) begin
                            s_nxt.st = stl_pkg::ST_IDLE;
                            s_nxt.busy = 1'b0;
                        end
                    end
                end
            end
        endcase
        // Expiry after the clear, so a coincident expiry is kept
        if (s_r.busy && tick_tmr && s_r.tms + 27'h1 >= s_r.tint) begin
            s_nxt.tms = 27'h0;
            s_nxt.tpend = 1'b1;
        end
        if (abort_w) begin
            s_nxt.st = stl_pkg::ST_IDLE;
            s_nxt.busy = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.st <= stl_pkg::ST_IDLE;
            s_r.src1 <= stl_pkg::SRC_RST;
            s_r.src2 <= stl_pkg::SRC_RST;
            s_r.srcc <= stl_pkg::SRC_RST;
            s_r.cnt1 <= stl_pkg::CNT_RST;
            s_r.cnt2 <= stl_pkg::CNT_RST;
            s_r.cntc <= stl_pkg::CNT_RST;
            s_r.dly2 <= stl_pkg::DLY_RST;
            s_r.dlyc <= stl_pkg::DLY_RST;
            s_r.tint <= stl_pkg::TMR_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.rdat;
    assign chan_step_o = s_r.step;
    assign busy_o = s_r.busy;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wr_ccnt;
        wr_acc && wb_adr_i == stl_pkg::A_CCNT;
    endsequence
    sequence s_trig_wait;
        s_r.st == stl_pkg::ST_TRIG && !abort_w;
    endsequence

    a_auto_follow_len: assert property (s_r.auto_on |->
        s_r.cntc == (($past(scan_len_i) == 16'h0) ? 16'h1 : $past(scan_len_i)))
        else $error("channel count does not follow list length");
    a_auto_empty_one: assert property ($rose(s_r.auto_on) && $past(scan_len_i) == 16'h0
        |-> s_r.cntc == 16'h1)
        else $error("empty list did not give count one");
    a_cnt_write_off: assert property (s_wr_ccnt |=> !s_r.auto_on)
        else $error("count write left auto-follow on");
    a_auto_readback: assert property ($rose(s_r.ack) && $past(wb_adr_i == stl_pkg::A_CTRL)
        |-> s_r.rdat == {31'h0, $past(s_r.auto_on)})
        else $error("auto-follow read back wrong");
    a_delay_range: assert property (s_r.dly2 <= stl_pkg::DLY_MAX_MS
        && s_r.dlyc <= stl_pkg::DLY_MAX_MS)
        else $error("delay beyond maximum");
    a_delay_wait: assert property (s_r.st == stl_pkg::ST_DLYC && s_r.dms != s_r.dlyc
        |=> s_r.st == stl_pkg::ST_DLYC || s_r.st == stl_pkg::ST_IDLE)
        else $error("channel delay cut short");
    a_arm1_nodelay: assert property (s_r.st == stl_pkg::ST_ARM1 && ok1 && !abort_w
        |=> s_r.st == stl_pkg::ST_ARM2)
        else $error("arm layer 1 did not leave at once");
    a_hold_stays: assert property (s_trig_wait ##0 (s_r.srcc == stl_pkg::SRC_HOLD && !sig_w)
        |=> s_r.st == stl_pkg::ST_TRIG)
        else $error("hold released without signal");
    a_pass_through: assert property (s_trig_wait ##0 s_r.srcc == stl_pkg::SRC_PASS
        |=> s_r.st == stl_pkg::ST_DLYC ##1 $past(s_r.st) == stl_pkg::ST_DLYC)
        else $error("pass-through source waited");
    a_bus_only: assert property (s_trig_wait ##0 (s_r.srcc == stl_pkg::SRC_BUS && !bus_w)
        |=> s_r.st == stl_pkg::ST_TRIG)
        else $error("bus source passed without trigger");
    a_timer_first: assert property (s_trig_wait ##0 (s_r.srcc == stl_pkg::SRC_TIMER && s_r.first)
        |=> s_r.st == stl_pkg::ST_DLYC)
        else $error("timer first pass not pass_through_source");
endmodule // stl_top

/* tb/stl_pin_model.sv */
// Far-side model: the external event pins (manual, external, trigger line).
// Assumes the bench calls pulse() from its own thread; pins idle low.
`timescale 1ns/10ps
module stl_pin_model (
    input wire logic clk_i,
    output stl_pkg::stl_pins_t pins_o
);
    initial pins_o = '0;
    // Held for several clocks so the two-flop synchroniser sees the edge
    task automatic pulse(input int idx);
        @(posedge clk_i);
        pins_o[idx] <= 1'b1;
        repeat (4) @(posedge clk_i);
        pins_o[idx] <= 1'b0;
    endtask
endmodule // stl_pin_model

/* tb/tb_top.sv */
// Self-checking bench for the trigger layer controller.
// Assumes the design answers Wishbone reads one cycle after the request.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
    logic clk_i = 0, rst_i = 1, cyc_r = 0, stb_r = 0, we_r = 0;
    logic [7:0] adr_r = '0;
    logic [3:0] sel_r = '0;
    logic [31:0] dat_r = '0, wb_dat_o;
    logic [15:0] scan_len_r = '0;
    logic wb_ack_o, chan_step_o, busy_o;
    stl_pkg::stl_pins_t pins;
    int num_errors = 0, samples_checked = 0, steps = 0, c, c0;
    logic [31:0] exp_q[$];
    always #12.5 clk_i = ~clk_i;
    stl_top #(.TICK_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_r),
        .wb_stb_i(stb_r), .wb_we_i(we_r), .wb_adr_i(adr_r), .wb_sel_i(sel_r),
        .wb_dat_i(dat_r), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .scan_len_i(scan_len_r), .pins_i(pins), .chan_step_o(chan_step_o), .busy_o(busy_o));
    stl_pin_model PIN (.clk_i(clk_i), .pins_o(pins));
    // Watcher: read data against oldest note, step pulses counted
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && we_r === 1'b0 && cyc_r === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(1, 0)
            end else begin
                `CHK(wb_dat_o, exp_q.pop_front())
            end
        end
        if (chan_step_o === 1'b1) steps++;
    end
    task automatic complete_run();
        $display("compares %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_r <= 1; stb_r <= 1; we_r <= we; adr_r <= a; dat_r <= d; sel_r <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            complete_run();
        end
        cyc_r <= 0; stb_r <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    // Waits for k steps within lim cycles; cc returns cycles taken
    task automatic wait_steps(input int k, input int lim, output int cc);
        cc = 0;
        while (steps < k && cc < lim) begin
            @(posedge clk_i);
            cc++;
        end
        `CHK(steps >= k, 1'b1)
        if (steps < k) complete_run();
    endtask
    task automatic go(input int k, output int cc);
        steps = 0;
        wr(stl_pkg::A_CMD, 32'h1);
        wait_steps(k, 300, cc);
    endtask
    task automatic idle();
        repeat (3) @(posedge clk_i);
        `CHK(busy_o, 1'b0)
    endtask
    initial begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
    initial begin
        logic [2:0] src;
        logic [15:0] len;
        int sel[5];
        sel = '{0, 3, 2, 4, 5};
        void'($urandom(2618));
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        rd(stl_pkg::A_CTRL, 32'h0);
        rd(stl_pkg::A_SRC, 32'h111);
        rd(stl_pkg::A_CCNT, 32'h1);
        rd(stl_pkg::A_DLY2, 32'h0);
        rd(8'h24, 32'h0);
        $display("test reset done");
        wr(stl_pkg::A_CTRL, 32'h1);
        rd(stl_pkg::A_CCNT, 32'h1);
        rd(stl_pkg::A_CTRL, 32'h1);
        // Kept aside, since scan_len_r only changes after this time step
        len = 16'($urandom_range(2, 200));
        scan_len_r <= len;
        rd(stl_pkg::A_CCNT, {16'h0, len});
        wr(stl_pkg::A_CCNT, 32'h5);
        rd(stl_pkg::A_CTRL, 32'h0);
        scan_len_r <= 16'h24;
        rd(stl_pkg::A_CCNT, 32'h5);
        wr(stl_pkg::A_CTRL, 32'h1);
        rd(stl_pkg::A_CCNT, 32'h24);
        wr(stl_pkg::A_CCNT, 32'h1);
        $display("test auto-follow done");
        wr(stl_pkg::A_DLY2, 32'h0FFFFFFF);
        rd(stl_pkg::A_DLY2, {5'h0, stl_pkg::DLY_MAX_MS});
        wr(stl_pkg::A_DLYC, 32'd99999999);
        rd(stl_pkg::A_DLYC, {5'h0, stl_pkg::DLY_MAX_MS});
        $display("test delay range done");
        wr(stl_pkg::A_DLY2, 32'h0);
        wr(stl_pkg::A_DLYC, 32'h0);
        go(1, c0);
        idle();
        wr(stl_pkg::A_DLYC, 32'h3);
        go(1, c);
        `CHK((c - c0 >= 11) && (c - c0 <= 14), 1'b1)
        idle();
        wr(stl_pkg::A_DLYC, 32'h0);
        wr(stl_pkg::A_DLY2, 32'h2);
        go(1, c);
        `CHK((c - c0 >= 7) && (c - c0 <= 10), 1'b1)
        idle();
        wr(stl_pkg::A_DLY2, 32'h0);
        $display("test delays done");
        // Hold, bus, manual, trigger line, external on the channel layer
        foreach (sel[i]) begin
            src = 3'(sel[i]);
            wr(stl_pkg::A_SRC, 32'h11 | (32'(src) << 8));
            steps = 0;
            wr(stl_pkg::A_CMD, 32'h1);
            repeat (20) @(posedge clk_i);
            `CHK(steps, 0)
            `CHK(busy_o, 1'b1)
            rd(stl_pkg::A_STAT, (32'h1 << stl_pkg::STAT_BUSY) | 32'(stl_pkg::ST_TRIG));
            case (src)
                3'h0: wr(stl_pkg::A_CMD, 32'h4);
                3'h3: wr(stl_pkg::A_CMD, 32'h8);
                3'h2: PIN.pulse(2);
                3'h4: PIN.pulse(0);
                default: PIN.pulse(1);
            endcase
            wait_steps(1, 20, c);
            idle();
        end
        $display("test sources done");
        wr(stl_pkg::A_SRC, 32'h011);
        wr(stl_pkg::A_CCNT, 32'h2);
        steps = 0;
        wr(stl_pkg::A_CMD, 32'h1);
        // Signal only counts once the channel layer is waiting
        repeat (4) @(posedge clk_i);
        wr(stl_pkg::A_CMD, 32'h4);
        wait_steps(1, 20, c);
        repeat (20) @(posedge clk_i);
        `CHK(steps, 1)
        wr(stl_pkg::A_CMD, 32'h4);
        wait_steps(2, 20, c);
        idle();
        $display("test hold reapply done");
        wr(stl_pkg::A_SRC, 32'h611);
        wr(stl_pkg::A_TMR, 32'h2);
        wr(stl_pkg::A_CCNT, 32'h3);
        go(1, c);
        `CHK(c <= 12, 1'b1)
        wait_steps(3, 60, c0);
        `CHK((c + c0 >= 16) && (c + c0 <= 40), 1'b1)
        idle();
        $display("test timer done");
        wr(stl_pkg::A_SRC, 32'h011);
        wr(stl_pkg::A_CMD, 32'h1);
        repeat (8) @(posedge clk_i);
        `CHK(busy_o, 1'b1)
        wr(stl_pkg::A_CMD, 32'h2);
        idle();
        $display("test abort done");
        complete_run();
    end
endmodule // tb_top
